// [logic/codec_pin_clock_agc_pkg.sv]
// Types shared by the pin, clock and AGC register slice.
// Assumes the figures come from codec_pin_clock_agc_regs.svh.
package codec_pin_clock_agc_pkg;

   // One register access from the control port decoder.
   typedef struct packed {
      logic       wr;     // Write strobe, one cycle.
      logic       rd;     // Read strobe, one cycle.
      logic [7:0] addr;   // Register offset.
      logic [7:0] wdata;  // Write data.
   } reg_req_t;

   // Read answer back to the control port decoder.
   typedef struct packed {
      logic       valid;  // One-cycle pulse with the data.
      logic [7:0] data;   // Read data.
   } reg_rsp_t;

   // Clock generation settings for the clock tree.
   typedef struct packed {
      logic       core_from_plain_divider; // Core clock source.
      logic [1:0] plain_divider_input;     // Plain divider source code.
      logic [1:0] pll_reference_input;     // PLL reference source code.
      logic [4:0] pll_n;                   // Decoded divider N, 2..17.
   } clock_ctrl_t;

   // Left AGC attack-time settings for the AGC core.
   typedef struct packed {
      logic        from_this_register; // Override the older register.
      logic [3:0]  baseline_ms;        // Baseline time in ms.
      logic [7:0]  multiplier;         // Power-of-two factor.
      logic [10:0] attack_ms;          // Product in ms.
   } agc_attack_t;

   // Progress of the strap capture after reset.
   typedef enum logic [1:0] {
      strap_settle,
      strap_held
   } strap_state_t;

endpackage

// [logic/codec_pin_clock_agc_regs.sv]
// Register slice for pin functions, clock generation and left AGC attack.
// Assumes a control port decoder on clk that issues one-cycle strobes.
//
// Summary of operation
// - Status bit shows pin one strap at reset
// - Status bit shows pin zero strap at reset
// - Enable bit allows pin three general input
// - Control bit routes pin three to audio data
// - Read bit returns sensed pin three level
// - Enable bit makes pin two general output
// - Level bit sets pin two driven level
// - Pin bits act only in two-wire mode
// - Core clock from PLL or plain divider
// - Two-bit field picks plain divider input
// - Two-bit field picks PLL reference input
// - N codes 0,1 mean 16,17; reset 2
// - Source bit picks older or this register
// - Baseline attack 7, 8, 10, 11 ms
// - Multiplier is two to the field value
// - Select high means serial peripheral mode
`timescale 1ns/1ns
`include "codec_pin_clock_agc_regs.svh"
module codec_pin_clock_agc_regs (
   input  wire logic                                clk,  // 100 MHz.
   input  wire logic                                reset, // Sync, high.
   input  codec_pin_clock_agc_pkg::reg_req_t        req,  // Access in.
   output codec_pin_clock_agc_pkg::reg_rsp_t        rsp,  // Read answer.
   input  wire logic                                interface_select,
   // Above: control mode pin, low for two-wire bus mode.
   input  wire logic multifunction_pin_zero_in,  // Strap for bit one.
   input  wire logic multifunction_pin_one_in,   // Strap for bit zero.
   input  wire logic multifunction_pin_three_in, // Input or audio data.
   output logic      multifunction_pin_two_out,  // Driven level.
   output logic      multifunction_pin_two_oe_n, // Low while driving.
   output logic      audio_serial_data_input,    // Routed audio data.
   output codec_pin_clock_agc_pkg::clock_ctrl_t clock_ctrl, // Clocks.
   output codec_pin_clock_agc_pkg::agc_attack_t agc_attack  // Left AGC.
);
   import codec_pin_clock_agc_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   logic [3:0] pins_sync;      // Select, pin three, pin one, pin zero.
   logic       spi_mode;       // Select pin high after sync.
   logic       pin3_level;     // Pin three after sync.
   logic       strap_zero_now; // Pin one after sync.
   logic       strap_one_now;  // Pin zero after sync.

   // Every pin level crosses two flip-flops before any logic.
   level_synchronizer #(
      .WIDTH (4)
   ) pin_sync (
      .clk      (clk),
      .reset    (reset),
      .async_in ({interface_select, multifunction_pin_three_in,
                  multifunction_pin_one_in, multifunction_pin_zero_in}),
      .sync_out (pins_sync)
   );

   assign spi_mode       = pins_sync[3];
   assign pin3_level     = pins_sync[2];
   assign strap_zero_now = pins_sync[1];
   assign strap_one_now  = pins_sync[0];

   ////////////////////////////////////////////////////////////////////
   // Storage.

   logic [7:0]   pin_ctrl;    // Writable bits of the pin register.
   logic [7:0]   clock_gen;   // Clock generation register.
   logic [7:0]   agc_attack_reg; // Left AGC attack-time register.
   logic         strap_zero;  // Latched strap for address bit zero.
   logic         strap_one;   // Latched strap for address bit one.
   logic [1:0]   settle_count; // Cycles waited since reset.
   strap_state_t strap_state; // Capture progress.
   logic         pin3_gpi_value; // Sensed pin three level, zero while input use is off.
   logic         two_wire_mode;  // Pin bits are in force.
   logic [7:0]   pin_read;    // Pin register as software sees it.
   logic [7:0]   next_rdata;  // Read mux result.
   logic         mapped;      // Offset belongs to this slice.

   assign two_wire_mode = ~spi_mode;

   // Control port writes; the pin register keeps only its writable bits, the other two store all eight.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pin_ctrl       <= `RST_PIN_FUNCTION_AND_CLOCK_SELECT;
         clock_gen      <= `RST_CLOCK_GENERATION_CONTROL;
         agc_attack_reg <= `RST_LEFT_AGC_ATTACK_TIME;
      end
      else if (req.wr)
      begin
         unique case (req.addr)
            `OFS_PIN_FUNCTION_AND_CLOCK_SELECT:
            begin
               // Status bits stay read-only.
               pin_ctrl <= req.wdata & `MASK_PIN_FUNCTION_WRITABLE;
            end
            `OFS_CLOCK_GENERATION_CONTROL:
            begin
               // Reserved source code is stored as written.
               clock_gen <= req.wdata;
            end
            `OFS_LEFT_AGC_ATTACK_TIME:
            begin
               // Low reserved bits are kept for read-back.
               agc_attack_reg <= req.wdata;
            end
            default:
            begin
               // Other offsets belong to other slices.
               pin_ctrl <= pin_ctrl;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Strap capture.

   // The straps are latched once, after the synchroniser has filled.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         strap_state  <= strap_settle;
         settle_count <= 2'h0;
         strap_zero   <= 1'b0;
         strap_one    <= 1'b0;
      end
      else
      begin
         unique case (strap_state)
            strap_settle:
            begin
               // Wait for sampled levels to reach the second stage.
               if (settle_count == `STRAP_SETTLE_CYCLES)
               begin
                  strap_zero  <= strap_zero_now;
                  strap_one   <= strap_one_now;
                  strap_state <= strap_held;
               end
               else
               begin
                  settle_count <= settle_count + 2'h1;
               end
            end
            strap_held:
            begin
               // Held until the next reset.
               strap_state <= strap_held;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Multifunction pins.

   // Pin three is sampled only while its input use is enabled.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pin3_gpi_value <= 1'b0;
      end
      else if (two_wire_mode && pin_ctrl[`BIT_PIN3_GPI_ENABLE])
      begin
         pin3_gpi_value <= pin3_level;
      end
      else
      begin
         pin3_gpi_value <= 1'b0;
      end
   end

   // Audio data routing from pin three, registered once.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         audio_serial_data_input <= 1'b0;
      end
      else
      begin
         audio_serial_data_input <= two_wire_mode &&
            pin_ctrl[`BIT_PIN3_AUDIO_SERIAL_DATA_INPUT_ENABLE] && pin3_level;
      end
   end

   // Pin two is driven only as an enabled output in two-wire mode.
   always_comb
   begin
      multifunction_pin_two_oe_n =
         ~(two_wire_mode && pin_ctrl[`BIT_PIN2_GPO_ENABLE]);
      multifunction_pin_two_out  = pin_ctrl[`BIT_PIN2_GPO_LEVEL];
   end

   ////////////////////////////////////////////////////////////////////
   // Clock and AGC decode.

   // Field decode for the clock tree and the left AGC.
   always_comb
   begin
      clock_ctrl.core_from_plain_divider =
         pin_ctrl[`BIT_CORE_CLOCK_SELECT];
      clock_ctrl.plain_divider_input =
         clock_gen[`MSB_PLAIN_DIVIDER_SOURCE:`LSB_PLAIN_DIVIDER_SOURCE];
      clock_ctrl.pll_reference_input =
         clock_gen[`MSB_PLL_REFERENCE_SOURCE:`LSB_PLL_REFERENCE_SOURCE];
      unique case (clock_gen[`MSB_PLL_N:`LSB_PLL_N])
         4'h0:    clock_ctrl.pll_n = `PLL_N_CODE_ZERO;
         4'h1:    clock_ctrl.pll_n = `PLL_N_CODE_ONE;
         default: clock_ctrl.pll_n = {1'b0, clock_gen[`MSB_PLL_N:`LSB_PLL_N]};
      endcase
      agc_attack.from_this_register =
         agc_attack_reg[`BIT_ATTACK_FROM_THIS_REG];
      unique case (agc_attack_reg[`MSB_ATTACK_BASELINE:`LSB_ATTACK_BASELINE])
         2'h0: agc_attack.baseline_ms = `ATTACK_MS_CODE0;
         2'h1: agc_attack.baseline_ms = `ATTACK_MS_CODE1;
         2'h2: agc_attack.baseline_ms = `ATTACK_MS_CODE2;
         2'h3: agc_attack.baseline_ms = `ATTACK_MS_CODE3;
      endcase
      agc_attack.multiplier = 8'h01 <<
         agc_attack_reg[`MSB_ATTACK_MULTIPLIER:`LSB_ATTACK_MULTIPLIER];
      agc_attack.attack_ms = {7'h00, agc_attack.baseline_ms}
                             * {3'h0, agc_attack.multiplier};
   end

   ////////////////////////////////////////////////////////////////////
   // Read path.

   // Status bits read zero outside two-wire mode.
   always_comb
   begin
      pin_read = pin_ctrl;
      pin_read[`BIT_STRAP_ZERO_STATUS] = two_wire_mode & strap_zero;
      pin_read[`BIT_STRAP_ONE_STATUS]  = two_wire_mode & strap_one;
      pin_read[`BIT_PIN3_GPI_VALUE]    = pin3_gpi_value;
      mapped = 1'b1;
      unique case (req.addr)
         `OFS_PIN_FUNCTION_AND_CLOCK_SELECT: next_rdata = pin_read;
         `OFS_CLOCK_GENERATION_CONTROL:      next_rdata = clock_gen;
         `OFS_LEFT_AGC_ATTACK_TIME:          next_rdata = agc_attack_reg;
         default:
         begin
            // Unmapped offsets answer nothing.
            next_rdata = 8'h00;
            mapped     = 1'b0;
         end
      endcase
   end

   // Read answer one cycle after the strobe; reads change no state.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rsp <= '0;
      end
      else
      begin
         rsp.valid <= req.rd && mapped;
         rsp.data  <= (req.rd && mapped) ? next_rdata : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Assertions.

   property p_read_answer;
      @(posedge clk) disable iff (reset)
      req.rd && req.addr == `OFS_CLOCK_GENERATION_CONTROL |=>
         rsp.valid && rsp.data == $past(clock_gen);
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("clock register read answer wrong");

   property p_n_sixteen;
      @(posedge clk) disable iff (reset)
      req.wr && req.addr == `OFS_CLOCK_GENERATION_CONTROL &&
         req.wdata[3:0] == 4'h0 |=> clock_ctrl.pll_n == 5'h10;
   endproperty
   a_n_sixteen: assert property (p_n_sixteen)
      else $error("pll n code zero not sixteen");

   property p_n_after_reset;
      @(posedge clk) disable iff (reset)
      $past(reset) |-> clock_ctrl.pll_n == 5'h02;
   endproperty
   a_n_after_reset: assert property (p_n_after_reset)
      else $error("pll n not two after reset");

   property p_pin_two_drive;
      @(posedge clk) disable iff (reset)
      req.wr && req.addr == `OFS_PIN_FUNCTION_AND_CLOCK_SELECT &&
         req.wdata[2:1] == 2'h3 ##1 !spi_mode |->
         !multifunction_pin_two_oe_n && multifunction_pin_two_out;
   endproperty
   a_pin_two_drive: assert property (p_pin_two_drive)
      else $error("pin two not driven high");

   property p_spi_releases_pin;
      @(posedge clk) disable iff (reset)
      spi_mode |-> multifunction_pin_two_oe_n
         ##1 !pin3_gpi_value && !audio_serial_data_input;
   endproperty
   a_spi_releases_pin: assert property (p_spi_releases_pin)
      else $error("pin function active in serial peripheral mode");

   property p_gpi_value;
      @(posedge clk) disable iff (reset)
      !spi_mode && pin_ctrl[`BIT_PIN3_GPI_ENABLE] ##1
         req.rd && req.addr == `OFS_PIN_FUNCTION_AND_CLOCK_SELECT |=>
         rsp.data[`BIT_PIN3_GPI_VALUE] == $past(pin3_level, 2);
   endproperty
   a_gpi_value: assert property (p_gpi_value)
      else $error("pin three input value wrong");

   property p_attack_max;
      @(posedge clk) disable iff (reset)
      req.wr && req.addr == `OFS_LEFT_AGC_ATTACK_TIME &&
         req.wdata == 8'hfc |=>
         agc_attack.attack_ms == 11'h580 && agc_attack.from_this_register;
   endproperty
   a_attack_max: assert property (p_attack_max)
      else $error("attack time not 1408 ms");

   property p_attack_base;
      @(posedge clk) disable iff (reset)
      req.wr && req.addr == `OFS_LEFT_AGC_ATTACK_TIME &&
         req.wdata == 8'h40 |=> agc_attack.attack_ms == 11'h00a;
   endproperty
   a_attack_base: assert property (p_attack_base)
      else $error("baseline attack time not 10 ms");

   property p_core_clock;
      @(posedge clk) disable iff (reset)
      req.wr && req.addr == `OFS_PIN_FUNCTION_AND_CLOCK_SELECT |=>
         clock_ctrl.core_from_plain_divider == $past(req.wdata[0]);
   endproperty
   a_core_clock: assert property (p_core_clock)
      else $error("core clock source not updated");

   property p_strap_stable;
      @(posedge clk) disable iff (reset)
      strap_state == strap_held |=> $stable(strap_zero) &&
         $stable(strap_one);
   endproperty
   a_strap_stable: assert property (p_strap_stable)
      else $error("strap status changed after capture");

endmodule

// [logic/codec_pin_clock_agc_regs.svh]
// Offsets, field positions, reset values and decode figures for the
// pin function, clock generation and left AGC attack-time registers.
// Assumes it is included by bare name wherever the figures are needed.
`ifndef CODEC_PIN_CLOCK_AGC_REGS_SVH
`define CODEC_PIN_CLOCK_AGC_REGS_SVH

// Register offsets on the control port.
`define OFS_PIN_FUNCTION_AND_CLOCK_SELECT 8'h65
`define OFS_CLOCK_GENERATION_CONTROL     8'h66
`define OFS_LEFT_AGC_ATTACK_TIME         8'h67

// Reset values.
`define RST_PIN_FUNCTION_AND_CLOCK_SELECT 8'h00
`define RST_CLOCK_GENERATION_CONTROL     8'h02
`define RST_LEFT_AGC_ATTACK_TIME         8'h00

// Bits of the pin function and clock select register.
`define BIT_STRAP_ZERO_STATUS 7
`define BIT_STRAP_ONE_STATUS  6
`define BIT_PIN3_GPI_ENABLE   5
`define BIT_PIN3_AUDIO_SERIAL_DATA_INPUT_ENABLE  4
`define BIT_PIN3_GPI_VALUE    3
`define BIT_PIN2_GPO_ENABLE   2
`define BIT_PIN2_GPO_LEVEL    1
`define BIT_CORE_CLOCK_SELECT 0
// Bits that software may write in that register.
`define MASK_PIN_FUNCTION_WRITABLE 8'h37

// Fields of the clock generation register.
`define MSB_PLAIN_DIVIDER_SOURCE 7
`define LSB_PLAIN_DIVIDER_SOURCE 6
`define MSB_PLL_REFERENCE_SOURCE 5
`define LSB_PLL_REFERENCE_SOURCE 4
`define MSB_PLL_N 3
`define LSB_PLL_N 0

// Fields of the left AGC attack-time register.
`define BIT_ATTACK_FROM_THIS_REG 7
`define MSB_ATTACK_BASELINE 6
`define LSB_ATTACK_BASELINE 5
`define MSB_ATTACK_MULTIPLIER 4
`define LSB_ATTACK_MULTIPLIER 2

// Clock source codes; code 2'h3 is reserved.
`define CLK_SRC_MASTER_CLOCK 2'h0
`define CLK_SRC_GENERAL_PIN_TWO 2'h1
`define CLK_SRC_BIT_CLOCK 2'h2

// PLL N figures for the two wrapped codes.
`define PLL_N_CODE_ZERO 5'h10
`define PLL_N_CODE_ONE  5'h11

// Baseline attack times in milliseconds.
`define ATTACK_MS_CODE0 4'h7
`define ATTACK_MS_CODE1 4'h8
`define ATTACK_MS_CODE2 4'ha
`define ATTACK_MS_CODE3 4'hb

// Cycles waited after reset release; the strap levels are latched on the edge after that.
`define STRAP_SETTLE_CYCLES 2'h2

`endif

// [logic/level_synchronizer.sv]
// Two-flip-flop synchroniser for levels that arrive from pins.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module level_synchronizer #(
   parameter int WIDTH = 1  // Number of independent levels.
) (
   input  wire logic             clk,     // System clock.
   input  wire logic             reset,   // Synchronous reset.
   input  wire logic [WIDTH-1:0] async_in, // Levels from outside.
   output logic      [WIDTH-1:0] sync_out  // Levels safe to use.
);

   logic [WIDTH-1:0] first_stage; // Read only by the second stage.

   // Both stages clear on reset and then shift on every edge.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         first_stage <= '0;
         sync_out    <= '0;
      end
      else
      begin
         first_stage <= async_in;
         sync_out    <= first_stage;
      end
   end

endmodule

// [verification/codec_host_model.sv]
// Host model that issues byte accesses on the register port.
// Assumes the bench calls its tasks only after reset is released.
`timescale 1ns/1ns
`include "codec_pin_clock_agc_regs.svh"
module codec_host_model (
   input  wire logic                         clk, // System clock.
   output codec_pin_clock_agc_pkg::reg_req_t req, // Access out.
   input  codec_pin_clock_agc_pkg::reg_rsp_t rsp  // Read answer.
);
   import codec_pin_clock_agc_pkg::*;

   // The port is idle from time zero.
   initial req = '0;

   ////////////////////////////////////////////////////////////////////
   // One write strobe, held for one edge, then dropped.
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      // A careful host never sends the reserved source code.
      if (a == `OFS_CLOCK_GENERATION_CONTROL && v[7:6] == 2'h3)
         v[7:6] = 2'h0;
      if (a == `OFS_CLOCK_GENERATION_CONTROL && v[5:4] == 2'h3)
         v[5:4] = 2'h0;
      // Reserved low bits of the attack register go out as zero.
      if (a == `OFS_LEFT_AGC_ATTACK_TIME)
         v[1:0] = 2'h0;
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clk);
      req <= '0;
   endtask

   // One read strobe; the answer is taken one edge after it is taken.
   task automatic read_reg(input logic [7:0] a, output logic ok,
                           output logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
      ok = rsp.valid;
      d = rsp.data;
   endtask
endmodule

// [verification/codec_pin_clock_agc_regs_test.sv]
// Self-checking bench for the pin, clock and left AGC register slice.
// Assumes the host model file and the design files are compiled first.
`timescale 1ns/1ns
`include "codec_pin_clock_agc_regs.svh"
module codec_pin_clock_agc_regs_test;
   import codec_pin_clock_agc_pkg::*;

   logic        clk;        // 100 MHz clock.
   logic        reset;      // Synchronous reset.
   logic        sel;        // Control mode pin.
   logic        pin_zero;   // Strap pin zero.
   logic        pin_one;    // Strap pin one.
   logic        pin_three;  // General input or audio data.
   logic        pin_two;    // Pin two level.
   logic        pin_two_n;  // Pin two enable, low drives.
   logic        audio;      // Routed audio data.
   reg_req_t    req;        // Host access.
   reg_rsp_t    rsp;        // Read answer.
   clock_ctrl_t clock_ctrl; // Clock settings.
   agc_attack_t agc;        // Attack settings.
   int          num_errors; // Mismatches.
   int          n_checks;   // Comparisons.
   logic [1:0]  s1;         // Plain divider source.
   logic [1:0]  s2;         // PLL reference source.
   logic [4:0]  en;         // Expected N.
   logic [3:0]  ms [4];     // Baseline times in ms.

   codec_host_model host (.clk(clk), .req(req), .rsp(rsp));

   codec_pin_clock_agc_regs dut (
      .clk                        (clk),
      .reset                      (reset),
      .req                        (req),
      .rsp                        (rsp),
      .interface_select           (sel),
      .multifunction_pin_zero_in  (pin_zero),
      .multifunction_pin_one_in   (pin_one),
      .multifunction_pin_three_in (pin_three),
      .multifunction_pin_two_out  (pin_two),
      .multifunction_pin_two_oe_n (pin_two_n),
      .audio_serial_data_input    (audio),
      .clock_ctrl                 (clock_ctrl),
      .agc_attack                 (agc)
   );

   // Free-running clock.
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////
   // Counts a comparison and reports a mismatch.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Reads a register and compares the answer flag and the data.
   task automatic rd(input logic [7:0] a, input logic ok,
                     input logic [7:0] e);
      logic       v;
      logic [7:0] d;
      host.read_reg(a, v, d);
      check({v, d}, {ok, e});
   endtask

   // Writes, then waits half a cycle, until the combinational outputs have settled; the registered audio output needs one more edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.write_reg(a, d);
      @(negedge clk);
   endtask

   // Holds reset for 8 edges with the given strap levels.
   task automatic do_reset(input logic z, input logic o);
      @(posedge clk);
      reset <= 1'b1;
      pin_zero <= z;
      pin_one <= o;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      repeat (6) @(posedge clk);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Cuts a hang short well beyond the expected run length.
   initial
   begin
      #200000;
      num_errors++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      ms = '{4'h7, 4'h8, 4'ha, 4'hb};
      num_errors = 0;
      n_checks = 0;
      reset = 1'b1;
      sel = 1'b0;
      pin_zero = 1'b0;
      pin_one = 1'b0;
      pin_three = 1'b0;
      do_reset(1'b1, 1'b0);
      // Reset values, strap status and an unmapped offset.
      rd(`OFS_PIN_FUNCTION_AND_CLOCK_SELECT, 1'b1, 8'h40);
      rd(`OFS_CLOCK_GENERATION_CONTROL, 1'b1, 8'h02);
      rd(`OFS_LEFT_AGC_ATTACK_TIME, 1'b1, 8'h00);
      rd(8'h68, 1'b0, 8'h00);
      check({pin_two_n, pin_two, audio}, 3'h4);
      $display("reset test done");
      // Pin two drive, core clock select and read-only bits.
      wr(`OFS_PIN_FUNCTION_AND_CLOCK_SELECT, 8'hff);
      check({pin_two_n, pin_two}, 2'h1);
      check(clock_ctrl.core_from_plain_divider, 1'b1);
      rd(`OFS_PIN_FUNCTION_AND_CLOCK_SELECT, 1'b1, 8'h77);
      wr(`OFS_PIN_FUNCTION_AND_CLOCK_SELECT, 8'h24);
      check({pin_two_n, pin_two, clock_ctrl[9]}, 3'h0);
      @(posedge clk);
      pin_three <= 1'b1;
      repeat (5) @(negedge clk);
      rd(`OFS_PIN_FUNCTION_AND_CLOCK_SELECT, 1'b1, 8'h6c);
      wr(`OFS_PIN_FUNCTION_AND_CLOCK_SELECT, 8'h10);
      repeat (4) @(negedge clk);
      check(audio, 1'b1);
      check(pin_two_n, 1'b1);
      rd(`OFS_PIN_FUNCTION_AND_CLOCK_SELECT, 1'b1, 8'h50);
      $display("pin test done");
      // Serial peripheral mode releases the two-wire pin functions.
      wr(`OFS_PIN_FUNCTION_AND_CLOCK_SELECT, 8'h37);
      @(posedge clk);
      sel <= 1'b1;
      repeat (4) @(negedge clk);
      check({pin_two_n, audio}, 2'h2);
      rd(`OFS_PIN_FUNCTION_AND_CLOCK_SELECT, 1'b1, 8'h37);
      @(posedge clk);
      sel <= 1'b0;
      repeat (4) @(negedge clk);
      check({pin_two_n, pin_two, audio}, 3'h3);
      rd(`OFS_PIN_FUNCTION_AND_CLOCK_SELECT, 1'b1, 8'h7f);
      $display("mode test done");
      // Every N code and every legal source code.
      for (int n = 0; n < 16; n++)
      begin
         s1 = 2'(n % 3);
         s2 = 2'((n + 1) % 3);
         en = (n == 0) ? 5'h10 : (n == 1) ? 5'h11 : 5'(n);
         wr(`OFS_CLOCK_GENERATION_CONTROL, {s1, s2, 4'(n)});
         check(clock_ctrl[8:0], {s1, s2, en});
         rd(`OFS_CLOCK_GENERATION_CONTROL, 1'b1, {s1, s2, 4'(n)});
      end
      $display("clock test done");
      // Every baseline and multiplier code of the attack time.
      for (int b = 0; b < 4; b++)
         for (int m = 0; m < 8; m++)
         begin
            wr(`OFS_LEFT_AGC_ATTACK_TIME, {1'b1, 2'(b), 3'(m), 2'h0});
            check(agc[23:11], {1'b1, ms[b], 8'(1 << m)});
            check(agc.attack_ms, 11'(ms[b] * (1 << m)));
         end
      wr(`OFS_LEFT_AGC_ATTACK_TIME, 8'h24);
      check(agc[23:11], {1'b0, ms[1], 8'h02});
      rd(`OFS_LEFT_AGC_ATTACK_TIME, 1'b1, 8'h24);
      wr(`OFS_LEFT_AGC_ATTACK_TIME, 8'h40);
      check(agc[23:11], {1'b0, ms[2], 8'h01});
      check(agc.attack_ms, 11'(ms[2]));
      $display("attack test done");
      // A second reset with the other strap levels.
      do_reset(1'b0, 1'b1);
      rd(`OFS_PIN_FUNCTION_AND_CLOCK_SELECT, 1'b1, 8'h80);
      rd(`OFS_CLOCK_GENERATION_CONTROL, 1'b1, 8'h02);
      check(clock_ctrl.pll_n, 5'h02);
      $display("strap test done");
      summarize();
   end
endmodule
